// ==== logic/emb_pkg.sv ====
package emb_pkg;
   // Register offsets on the special-register port
   localparam logic [7:0] EXTERNAL_PAGE_BYTE_OFS = 8'h92;
   localparam logic [7:0] CONFIG_INDEX_LO_OFS = 8'h93;
   localparam logic [7:0] CONFIG_INDEX_HI_OFS = 8'h94;
   localparam logic [7:0] CONFIG_VALUE_OFS = 8'h95;
   // Configuration memory map
   localparam logic [15:0] CONFIG_BASE = 16'h8000;
   localparam logic [15:0] PORT_FUNCTION_CONFIG_ADDR = 16'h807e;
   localparam logic [15:0] FLASH_PARTITION_CONFIG_ADDR = 16'h807f;
   localparam logic [15:0] CONFIG_LOCK_LO = 16'h8070;
   localparam logic [15:0] CONFIG_LOCK_HI = 16'h8079;
   localparam int CONFIG_BYTES = 128;
   localparam logic [7:0] CONFIG_ERASED = 8'hff;
   localparam logic [7:0] EXTERNAL_PAGE_RESET = 8'h00;
   localparam logic [15:0] CONFIG_INDEX_RESET = 16'h0000;
   // Field positions
   localparam int PF_P2_BIT = 0;
   localparam int PF_P0_BIT = 1;
   localparam int PART_SEL_LSB = 0;
   // Address map
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] BOOT_ROM_BASE = 16'hf800;
   localparam logic [15:0] SRAM_TOP = 16'h03ff;
   localparam logic [15:0] DATA_FLASH_BASE = 16'h0400;
   localparam int KB = 1024;
   // Bus strobe length in core_clk cycles and fixed bus data values
   localparam logic [3:0] STROBE_CYC = 4'h2;
   localparam logic [7:0] UNDRIVEN_READ = 8'hff;
   localparam logic [7:0] SECRET_DATA = 8'h00;

   typedef enum logic [1:0] {
      EMB_FETCH,
      EMB_READ,
      EMB_WRITE
   } emb_kind_type;

   typedef struct packed {
      emb_kind_type kind;
      logic short_addr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } emb_req_type;

   typedef struct packed {
      logic [7:0] rdata;
      logic internal;
   } emb_resp_type;
endpackage

// ==== logic/emb_bus.sv ====
`timescale 1ns/1ps
// What this block does
// - After reset the first instruction fetch is taken from address 0000h.
// - Internal-access pin high: fetches inside internal program range served internally.
// - Internal-access pin low: every fetch outside an enabled boot ROM goes to external program memory.
// - Pin sampled at reset; low makes all data and all code except enabled boot ROM fetches external.
// - Boot ROM enabled: fetches at F800h-FFFFh go to the boot ROM.
// - Internal program size is a build parameter of 4k, 8k, 16k or 32k.
// - Bus enabled only when port-function bits 0 and 1 are cleared.
// - Internal access data phase drives the multiplexed port to zeros.
// - Program-read strobe for fetches; read and write strobes for data.
// - Fetches use 16-bit addresses; data uses 16-bit or 8-bit addresses.
// - Either port-function bit cleared takes high port and strobe pins.
// - 8-bit data accesses hold the page byte on the high port.
// - Low address is valid on the port at the falling address-latch edge.
// - Write data stands before the write strobe and after its release.
// - Read data is sampled one core_clk cycle before the read strobe is released.
// - Bus pins are driven actively to both levels.
// - Ports default to general I/O; external accesses then leave pins unchanged.
// - External fetches put the program counter high byte on the high port.
// - User mode: configuration memory readable through index and value, never written.
// - Programming mode: all readable; writable except 8070h-8079h.
// - Port-function byte at 807Eh, partition byte at 807Fh, programming mode only.
// - Programming mode decodes 16-bit config addresses; user mode 8-bit.
// - Partitioning shrinks internal program range from its top.
// - Data SRAM at 0000h-03FFh, data flash directly above from 0400h.
module emb_bus import emb_pkg::*; #(
   parameter int PROG_KB = 32
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic internal_access_pin,
   input wire logic programming_mode,
   input wire logic boot_rom_en,
   input wire logic req_valid,
   input wire emb_req_type req,
   output logic req_ready,
   output logic resp_valid,
   output emb_resp_type resp,
   output logic mem_int_sel,
   input wire logic [7:0] int_rdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] gpio_p0_out,
   input wire logic [7:0] gpio_p0_oe,
   input wire logic [7:0] gpio_p2_out,
   input wire logic [7:0] gpio_p2_oe,
   input wire logic [1:0] gpio_p3_out,
   input wire logic [1:0] gpio_p3_oe,
   input wire logic [7:0] p0_in,
   output logic [7:0] p0_out,
   output logic [7:0] p0_oe,
   output logic [7:0] p2_out,
   output logic [7:0] p2_oe,
   output logic [1:0] p3_out,
   output logic [1:0] p3_oe,
   output logic ale,
   output logic program_read_strobe_n
);

   typedef enum logic [2:0] {
      ST_STRAP,
      ST_IDLE,
      ST_DIRECT,
      ST_ADDR,
      ST_LATCH,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } emb_state_type;

   // Internal program top in kB after partitioning
   function automatic logic [15:0] prog_kb(input logic [2:0] sel);
      logic [15:0] dm;
      dm = 16'(data_kb(sel));
      prog_kb = (dm >= 16'(PROG_KB)) ? 16'h0000 : 16'(PROG_KB) - dm;
   endfunction

   // Data flash size in kB for a partition select
   function automatic logic [15:0] data_kb(input logic [2:0] sel);
      data_kb = 16'h0000;
      unique case (sel)
         3'h0, 3'h1: data_kb = 16'(PROG_KB);
         3'h2: data_kb = 16'h0010;
         3'h3: data_kb = 16'h0008;
         3'h4: data_kb = 16'h0004;
         3'h5: data_kb = 16'h0002;
         3'h6: data_kb = 16'h0001;
         3'h7: data_kb = 16'h0000;
      endcase
      if (data_kb > 16'(PROG_KB)) begin
         data_kb = 16'(PROG_KB);
      end
   endfunction

   logic [7:0] cfg_mem [CONFIG_BYTES];
   logic [7:0] next_cfg_byte, next_sfr_rdata;
   logic cfg_we, cfg_hit;
   logic [6:0] cfg_idx;
   logic [7:0] external_page_byte, next_external_page_byte;
   logic [15:0] config_index_reg, next_config_index_reg;
   emb_state_type state, next_state;
   emb_req_type cur, next_cur;
   logic cur_int, next_cur_int;
   logic ext_only, next_ext_only;
   logic [3:0] cnt, next_cnt;
   logic next_resp_valid, next_ale, next_prs_n;
   emb_resp_type next_resp;
   logic [7:0] next_p0_out, next_p0_oe, next_p2_out, next_p2_oe;
   logic [1:0] next_p3_out, next_p3_oe;
   logic [7:0] port_function_config, flash_partition_config;
   logic bus_en, hi_owned;
   logic [2:0] part_sel;
   logic [7:0] hi_byte;

   assign port_function_config = cfg_mem[PORT_FUNCTION_CONFIG_ADDR[6:0]];
   assign flash_partition_config = cfg_mem[FLASH_PARTITION_CONFIG_ADDR[6:0]];
   assign part_sel = flash_partition_config[PART_SEL_LSB +: 3];
   assign bus_en = ~port_function_config[PF_P2_BIT] & ~port_function_config[PF_P0_BIT];
   assign hi_owned = ~port_function_config[PF_P2_BIT] | ~port_function_config[PF_P0_BIT];

   // Decide whether an access is served internally
   function automatic logic is_internal(input emb_req_type r, input logic xo,
                                        input logic [2:0] sel, input logic boot);
      logic [16:0] top;
      top = 17'(prog_kb(sel)) * 17'(KB);
      is_internal = 1'b0;
      if (r.kind == EMB_FETCH) begin
         if (boot && r.addr >= BOOT_ROM_BASE) begin
            is_internal = 1'b1;
         end else begin
            is_internal = !xo && (17'(r.addr) < top);
         end
      end else if (!xo) begin
         top = 17'(DATA_FLASH_BASE) + 17'(data_kb(sel)) * 17'(KB);
         is_internal = r.short_addr ? 1'b1 : (17'(r.addr) < top);
      end
   endfunction

   // Configuration memory index decode
   always_comb begin
      cfg_hit = programming_mode ? (config_index_reg[15:7] == CONFIG_BASE[15:7])
                                 : ~config_index_reg[7];
      cfg_idx = config_index_reg[6:0];
   end

   // Special-register port
   always_comb begin
      next_external_page_byte = external_page_byte;
      next_config_index_reg = config_index_reg;
      next_sfr_rdata = sfr_rdata;
      cfg_we = 1'b0;
      next_cfg_byte = sfr_wdata;
      if (sfr_wr) begin
         unique case (sfr_addr)
            EXTERNAL_PAGE_BYTE_OFS: next_external_page_byte = sfr_wdata;
            CONFIG_INDEX_LO_OFS: next_config_index_reg[7:0] = sfr_wdata;
            CONFIG_INDEX_HI_OFS: next_config_index_reg[15:8] = sfr_wdata;
            CONFIG_VALUE_OFS: begin
               cfg_we = programming_mode && cfg_hit &&
                        !(config_index_reg >= CONFIG_LOCK_LO &&
                          config_index_reg <= CONFIG_LOCK_HI);
            end
            default: ;
         endcase
      end
      if (sfr_rd) begin
         unique case (sfr_addr)
            EXTERNAL_PAGE_BYTE_OFS: next_sfr_rdata = external_page_byte;
            CONFIG_INDEX_LO_OFS: next_sfr_rdata = config_index_reg[7:0];
            CONFIG_INDEX_HI_OFS: next_sfr_rdata = config_index_reg[15:8];
            CONFIG_VALUE_OFS: next_sfr_rdata = cfg_hit ? cfg_mem[cfg_idx] : CONFIG_ERASED;
            default: next_sfr_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         external_page_byte <= EXTERNAL_PAGE_RESET;
         config_index_reg <= CONFIG_INDEX_RESET;
         sfr_rdata <= 8'h00;
         for (int i = 0; i < CONFIG_BYTES; i++) begin
            cfg_mem[i] <= CONFIG_ERASED;
         end
      end else begin
         external_page_byte <= next_external_page_byte;
         config_index_reg <= next_config_index_reg;
         sfr_rdata <= next_sfr_rdata;
         if (cfg_we) begin
            cfg_mem[cfg_idx] <= next_cfg_byte;
         end
      end
   end

   // High address byte of the current access
   assign hi_byte = (cur.kind != EMB_FETCH && cur.short_addr) ? external_page_byte
                    : cur.addr[15:8];

   assign req_ready = (state == ST_IDLE);
   assign mem_int_sel = cur_int && (state != ST_IDLE) && (state != ST_STRAP);

   // Bus cycle sequencer
   always_comb begin
      next_state = state;
      next_cur = cur;
      next_cur_int = cur_int;
      next_ext_only = ext_only;
      next_cnt = cnt;
      next_resp_valid = 1'b0;
      next_resp = resp;
      next_ale = 1'b0;
      next_prs_n = 1'b1;
      next_p0_out = gpio_p0_out;
      next_p0_oe = gpio_p0_oe;
      next_p2_out = hi_owned ? p2_out : gpio_p2_out;
      next_p2_oe = hi_owned ? 8'hff : gpio_p2_oe;
      next_p3_out = hi_owned ? 2'b11 : gpio_p3_out;
      next_p3_oe = hi_owned ? 2'b11 : gpio_p3_oe;
      if (bus_en) begin
         next_p0_out = p0_out;
         next_p0_oe = p0_oe;
      end
      unique case (state)
         ST_STRAP: begin
            next_ext_only = ~internal_access_pin;
            next_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (req_valid) begin
               next_cur = req;
               if (req.kind != EMB_FETCH && req.short_addr) begin
                  next_cur.addr = {8'h00, req.addr[7:0]};
               end
               next_cur_int = is_internal(req, ext_only, part_sel, boot_rom_en);
               next_state = bus_en ? ST_ADDR : ST_DIRECT;
            end
         end
         ST_DIRECT: begin
            next_resp_valid = 1'b1;
            next_resp.internal = cur_int;
            next_resp.rdata = cur_int ? int_rdata : UNDRIVEN_READ;
            next_state = ST_IDLE;
         end
         ST_ADDR: begin
            next_ale = 1'b1;
            next_p0_out = cur.addr[7:0];
            next_p0_oe = 8'hff;
            next_p2_out = hi_byte;
            next_state = ST_LATCH;
         end
         ST_LATCH: begin
            next_p2_out = hi_byte;
            next_state = ST_SETUP;
         end
         ST_SETUP: begin
            next_p2_out = hi_byte;
            if (cur_int) begin
               next_p0_out = SECRET_DATA;
               next_p0_oe = 8'hff;
            end else if (cur.kind == EMB_WRITE) begin
               next_p0_out = cur.wdata;
               next_p0_oe = 8'hff;
            end else begin
               next_p0_oe = 8'h00;
            end
            next_cnt = STROBE_CYC;
            next_state = ST_STROBE;
         end
         ST_STROBE: begin
            next_p2_out = hi_byte;
            if (!cur_int) begin
               unique case (cur.kind)
                  EMB_FETCH: next_prs_n = 1'b0;
                  EMB_READ: next_p3_out = 2'b01;
                  EMB_WRITE: next_p3_out = 2'b10;
                  default: ;
               endcase
            end
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
               next_state = ST_HOLD;
               next_resp.internal = cur_int;
               next_resp.rdata = cur_int ? int_rdata : p0_in;
            end
         end
         ST_HOLD: begin
            next_p2_out = hi_byte;
            next_resp_valid = 1'b1;
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_STRAP;
         cur <= '{kind: EMB_FETCH, short_addr: 1'b0, addr: RESET_VECTOR, wdata: 8'h00};
         cur_int <= 1'b0;
         ext_only <= 1'b0;
         cnt <= 4'h0;
         resp_valid <= 1'b0;
         resp <= '0;
         ale <= 1'b0;
         program_read_strobe_n <= 1'b1;
         p0_out <= 8'h00;
         p0_oe <= 8'h00;
         p2_out <= 8'h00;
         p2_oe <= 8'h00;
         p3_out <= 2'b11;
         p3_oe <= 2'b00;
      end else begin
         state <= next_state;
         cur <= next_cur;
         cur_int <= next_cur_int;
         ext_only <= next_ext_only;
         cnt <= next_cnt;
         resp_valid <= next_resp_valid;
         resp <= next_resp;
         ale <= next_ale;
         program_read_strobe_n <= next_prs_n;
         p0_out <= next_p0_out;
         p0_oe <= next_p0_oe;
         p2_out <= next_p2_out;
         p2_oe <= next_p2_oe;
         p3_out <= next_p3_out;
         p3_oe <= next_p3_oe;
      end
   end

endmodule

// ==== verif/emb_bus_props.sv ====
`timescale 1ns/1ps
module emb_bus_props import emb_pkg::*; (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire emb_req_type req,
   input wire logic req_ready,
   input wire logic mem_int_sel,
   input wire logic [7:0] p0_out,
   input wire logic [7:0] p0_oe,
   input wire logic [7:0] p2_out,
   input wire logic [7:0] p2_oe,
   input wire logic [1:0] p3_out,
   input wire logic [1:0] p3_oe,
   input wire logic ale,
   input wire logic program_read_strobe_n
);
   emb_req_type taken;
   emb_req_type next_taken;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Request of the bus cycle in progress
   always_comb begin
      next_taken = (req_valid && req_ready) ? req : taken;
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         taken <= '0;
      end else begin
         taken <= next_taken;
      end
   end
   sequence latch_s;
      ale ##1 !ale;
   endsequence
   sequence wr_low_s;
      p3_oe[0] && !p3_out[0];
   endsequence
   ale_single_a: assert property (ale |=> (!ale) [*5])
      else $error("latch pulse repeated");
   strobe_order_a: assert property ($fell(program_read_strobe_n) |->
      !ale && ($past(ale, 2) || $past(ale, 3))) else $error("strobe without latch pulse");
   addr_latch_a: assert property (latch_s |-> p0_out == taken.addr[7:0])
      else $error("low address not held at latch fall");
   fetch_high_a: assert property (ale && !taken.short_addr |-> p2_out == taken.addr[15:8])
      else $error("high address wrong");
   page_hold_a: assert property (ale |=> $stable(p2_out) [*4])
      else $error("high port moved");
   wr_setup_a: assert property (wr_low_s |-> p0_oe == 8'hff && $stable(p0_out))
      else $error("write data moved");
   wr_hold_a: assert property ($rose(p3_out[0]) && p3_oe[0] |->
      p0_oe == 8'hff && $stable(p0_out)) else $error("write data dropped");
   secret_data_a: assert property (latch_s ##1 mem_int_sel |-> p0_out == SECRET_DATA)
      else $error("internal data shown on port");
   pins_driven_a: assert property (ale |-> p0_oe == 8'hff && p2_oe == 8'hff && p3_oe == 2'b11)
      else $error("bus pins not driven");
endmodule
bind emb_bus emb_bus_props i_emb_bus_props (.core_clk, .nrst, .req_valid, .req, .req_ready,
   .mem_int_sel, .p0_out, .p0_oe, .p2_out, .p2_oe, .p3_out, .p3_oe, .ale, .program_read_strobe_n);

// ==== verif/emb_mem_model.sv ====
`timescale 1ns/1ps
module emb_mem_model (
   input wire logic ale,
   input wire logic program_read_strobe_n,
   input wire logic [1:0] p3_out,
   input wire logic [1:0] p3_oe,
   input wire logic [7:0] p0_out,
   input wire logic [7:0] p0_oe,
   input wire logic [7:0] p2_out,
   output logic [7:0] p0_in
);
   logic [7:0] mem [logic [15:0]];
   logic [7:0] lo = 8'h00;
   logic [7:0] drv = 8'h00;
   wire logic rd_on = !program_read_strobe_n || (p3_oe[1] && !p3_out[1]);
   // External latch catches the low address as the latch strobe falls
   always @(negedge ale) lo = p0_out;
   // Write data taken as the write strobe is released
   always @(posedge p3_out[0]) if (p3_oe[0] === 1'b1) mem[{p2_out, lo}] = p0_out;
   // Data stands through the read strobe; otherwise inverted, never the last value
   always @(rd_on or p2_out or lo) begin
      if (rd_on !== 1'b1) begin
         drv = ~drv;
      end else if (mem.exists({p2_out, lo})) begin
         drv = mem[{p2_out, lo}];
      end else begin
         drv = 8'hc3 ^ lo ^ p2_out;
      end
   end
   assign p0_in = (p0_oe & p0_out) | (~p0_oe & drv);
endmodule

// ==== verif/emb_bus_tb_top.sv ====
`timescale 1ns/1ps
module emb_bus_tb_top import emb_pkg::*; ;
   logic core_clk = 1'b0;
   logic nrst = 1'b0, internal_access_pin = 1'b1, programming_mode = 1'b0, boot_rom_en = 1'b0;
   logic req_valid = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, gpio_p0_out = 8'h00, gpio_p2_out = 8'h00;
   logic [7:0] int_rdata = 8'h77;
   logic [1:0] gpio_p3_out = 2'b01;
   emb_req_type req = '0;
   emb_resp_type resp, rsp;
   logic req_ready, resp_valid, mem_int_sel, ale, program_read_strobe_n;
   logic [7:0] sfr_rdata, p0_in, p0_out, p0_oe, p2_out, p2_oe;
   logic [1:0] p3_out, p3_oe;
   int fails = 0, cmp_count = 0, cyc = 0;
   emb_bus #(.PROG_KB(32)) i_emb_bus (.core_clk, .nrst, .internal_access_pin, .programming_mode,
      .boot_rom_en, .req_valid, .req, .req_ready, .resp_valid, .resp, .mem_int_sel,
      .int_rdata, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .gpio_p0_out,
      .gpio_p0_oe(8'hff), .gpio_p2_out, .gpio_p2_oe(8'hff), .gpio_p3_out,
      .gpio_p3_oe(2'b00), .p0_in, .p0_out, .p0_oe, .p2_out, .p2_oe, .p3_out, .p3_oe, .ale,
      .program_read_strobe_n);
   emb_mem_model i_emb_mem_model (.ale, .program_read_strobe_n, .p3_out, .p3_oe, .p0_out,
      .p0_oe, .p2_out, .p0_in);
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic ck(input string nm, input logic [7:0] ex, input logic [7:0] got);
      cmp_count++;
      if (got !== ex) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic acc(input emb_kind_type k, input logic s, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{kind: k, short_addr: s, addr: a, wdata: d};
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 1'b0;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (resp_valid === 1'b1) break;
      end
      rsp = resp;
      ck("answer", 8'h01, {7'h0, resp_valid});
   endtask
   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfr_wr <= w;
      sfr_rd <= !w;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic cfg(input logic [15:0] idx, input logic w, input logic [7:0] d);
      sfr(1'b1, CONFIG_INDEX_LO_OFS, idx[7:0]);
      sfr(1'b1, CONFIG_INDEX_HI_OFS, idx[15:8]);
      sfr(w, CONFIG_VALUE_OFS, d);
   endtask
   task automatic pmode(input logic m);
      @(posedge core_clk);
      programming_mode <= m;
   endtask
   task automatic t_bus_off();
      gpio_p0_out <= 8'ha5;
      gpio_p2_out <= 8'h3c;
      acc(EMB_FETCH, 1'b0, RESET_VECTOR, 8'h00);
      ck("vector", 8'h01, {7'h0, rsp.internal});
      acc(EMB_FETCH, 1'b0, 16'h7fff, 8'h00);
      ck("top", 8'h01, {7'h0, rsp.internal});
      acc(EMB_FETCH, 1'b0, 16'h8000, 8'h00);
      ck("above", 8'h00, {7'h0, rsp.internal});
      ck("off_rd", UNDRIVEN_READ, rsp.rdata);
      ck("off_p0", 8'ha5, p0_out);
      ck("off_p2", 8'h3c, p2_out);
      ck("off_p3", 8'h01, {6'h0, p3_out});
   endtask
   task automatic t_config();
      cfg(PORT_FUNCTION_CONFIG_ADDR, 1'b1, 8'h00);
      cfg(PORT_FUNCTION_CONFIG_ADDR, 1'b0, 8'h00);
      ck("user_wr", CONFIG_ERASED, sfr_rdata);
      pmode(1'b1);
      for (int i = 0; i < 10; i++) begin
         cfg(CONFIG_LOCK_LO + 16'(i), 1'b1, 8'h00);
         cfg(CONFIG_LOCK_LO + 16'(i), 1'b0, 8'h00);
         ck("locked", CONFIG_ERASED, sfr_rdata);
      end
      cfg(16'h807a, 1'b1, 8'h5c);
      cfg(16'h807a, 1'b0, 8'h00);
      ck("open", 8'h5c, sfr_rdata);
      cfg(PORT_FUNCTION_CONFIG_ADDR, 1'b1, 8'hfe);
      acc(EMB_READ, 1'b0, 16'h9000, 8'h00);
      ck("half_p0", 8'ha5, p0_out);
      ck("half_p2", 8'hff, p2_oe);
      ck("half_p3", 8'h03, {6'h0, p3_oe});
      ck("half_p3o", 8'h03, {6'h0, p3_out});
      cfg(PORT_FUNCTION_CONFIG_ADDR, 1'b1, 8'h00);
      cfg(FLASH_PARTITION_CONFIG_ADDR, 1'b1, 8'h06);
      pmode(1'b0);
      cfg(16'h007e, 1'b0, 8'h00);
      ck("user_rd", 8'h00, sfr_rdata);
      cfg(16'h007f, 1'b0, 8'h00);
      ck("part_rd", 8'h06, sfr_rdata);
   endtask
   task automatic t_bus_rw();
      acc(EMB_WRITE, 1'b0, 16'h9000, 8'h5a);
      acc(EMB_READ, 1'b0, 16'h9000, 8'h00);
      ck("rd_back", 8'h5a, rsp.rdata);
      acc(EMB_FETCH, 1'b0, 16'h8123, 8'h00);
      ck("fetch", 8'h61, rsp.rdata);
      acc(EMB_FETCH, 1'b0, 16'h7bff, 8'h00);
      ck("part_top", 8'h01, {7'h0, rsp.internal});
      acc(EMB_FETCH, 1'b0, 16'h7c00, 8'h00);
      ck("part_ext", 8'h00, {7'h0, rsp.internal});
      ck("part_data", 8'hbf, rsp.rdata);
      acc(EMB_READ, 1'b0, 16'h07ff, 8'h00);
      ck("dflash", 8'h01, {7'h0, rsp.internal});
      acc(EMB_READ, 1'b0, 16'h0800, 8'h00);
      ck("dflash_end", 8'h00, {7'h0, rsp.internal});
      acc(EMB_READ, 1'b0, SRAM_TOP, 8'h00);
      ck("sram", 8'h01, {7'h0, rsp.internal});
      ck("sram_rd", 8'h77, rsp.rdata);
      @(posedge core_clk);
      boot_rom_en <= 1'b1;
      acc(EMB_FETCH, 1'b0, BOOT_ROM_BASE, 8'h00);
      ck("boot", 8'h01, {7'h0, rsp.internal});
      acc(EMB_FETCH, 1'b0, 16'hffff, 8'h00);
      ck("boot_top", 8'h01, {7'h0, rsp.internal});
      @(posedge core_clk);
      boot_rom_en <= 1'b0;
      acc(EMB_FETCH, 1'b0, BOOT_ROM_BASE, 8'h00);
      ck("no_boot", 8'h3b, rsp.rdata);
   endtask
   task automatic t_strap_low();
      @(posedge core_clk);
      nrst <= 1'b0;
      internal_access_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      sfr(1'b0, EXTERNAL_PAGE_BYTE_OFS, 8'h00);
      ck("page_rst", EXTERNAL_PAGE_RESET, sfr_rdata);
      pmode(1'b1);
      cfg(PORT_FUNCTION_CONFIG_ADDR, 1'b1, 8'h00);
      pmode(1'b0);
      internal_access_pin <= 1'b1;
      acc(EMB_FETCH, 1'b0, RESET_VECTOR, 8'h00);
      ck("ext_vec", 8'hc3, rsp.rdata);
      acc(EMB_READ, 1'b0, 16'h0010, 8'h00);
      ck("ext_data", 8'h00, {7'h0, rsp.internal});
      sfr(1'b1, EXTERNAL_PAGE_BYTE_OFS, 8'h9a);
      acc(EMB_WRITE, 1'b1, 16'h0040, 8'h66);
      acc(EMB_READ, 1'b0, 16'h9a40, 8'h00);
      ck("paged", 8'h66, rsp.rdata);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      t_bus_off();
      t_config();
      t_bus_rw();
      t_strap_low();
      report_and_stop();
   end
endmodule
